// ### cpm_pkg.sv
package cpm_pkg;
  localparam int          CLK_NS        = 50;
  localparam logic [7:0]  MGMT_DEV_ADDR = 8'hac;
  // Register offsets
  localparam logic [4:0]  REG_PHY_CTRL  = 5'h00;
  localparam logic [4:0]  REG_ADV       = 5'h04;
  localparam logic [4:0]  REG_LINK_STAT = 5'h11;
  localparam logic [4:0]  REG_EXT_CTRL  = 5'h14;
  localparam logic [4:0]  REG_BANK_SEL  = 5'h16;
  localparam logic [4:0]  REG_IND_PTR   = 5'h1d;
  localparam logic [4:0]  REG_IND_DATA  = 5'h1e;
  // Field positions
  localparam int          CTRL_SOFT_RST = 15;
  localparam int          CTRL_LOOPBACK = 14;
  localparam int          CTRL_AN_EN    = 12;
  localparam int          STAT_LINK_UP  = 10;
  localparam int          EXT_LINE_LB   = 14;
  localparam int          ADV_PREF_MSTR = 10;
  localparam logic [15:0] BANK_HOST     = 16'h0001;
  localparam logic [15:0] BANK_CABLE    = 16'h0000;
  // Reset values
  localparam logic [15:0] CTRL_RST_VAL  = 16'h1140;
  localparam logic [15:0] ADV_RST_VAL   = 16'h0de1;
  localparam logic [15:0] ADV_MERGE_MSK = 16'h0de0;
  // Write data used by the controller sequences
  localparam logic [15:0] CTRL_AN_OFF   = 16'h8140;
  localparam logic [15:0] CTRL_AN_ON    = 16'h9140;
  localparam logic [15:0] CTRL_ILB_ON   = 16'h4140;
  localparam logic [15:0] CTRL_ILB_OFF  = 16'h0140;
  localparam logic [15:0] EXT_LLB_ON    = 16'h4000;
  localparam logic [15:0] EXT_LLB_OFF   = 16'h0000;
  localparam logic [15:0] ADV_B2B_FD    = 16'h0141;
  localparam logic [15:0] IND_PTR_A     = 16'h0006;
  localparam logic [15:0] IND_DATA_A    = 16'h4200;
  localparam logic [15:0] IND_PTR_B     = 16'h000a;
  localparam logic [15:0] IND_DATA_B    = 16'h0001;
  // Timing
  localparam int          RST_DONE_NS   = 1000;
  localparam int          RST_DONE_CYC  = (RST_DONE_NS + CLK_NS - 1) / CLK_NS;
  localparam int          POLL_NS       = 100000;
  localparam int          POLL_CYC      = POLL_NS / CLK_NS;
  // Controller command port
  localparam logic [3:0]  HR_CMD        = 4'h0;
  localparam logic [3:0]  HR_CTRL       = 4'h1;
  localparam logic [3:0]  HR_RAW_ADDR   = 4'h2;
  localparam logic [3:0]  HR_RAW_DATA   = 4'h3;
  localparam logic [3:0]  HR_STATUS     = 4'h4;
  localparam logic [3:0]  HR_RDATA      = 4'h5;
  typedef enum logic [3:0] {
    SEQ_PULSE, SEQ_HAN_OFF, SEQ_HAN_ON, SEQ_LLB_ON, SEQ_LLB_OFF,
    SEQ_ILB_ON, SEQ_ILB_OFF, SEQ_B2B, SEQ_RAW_WR, SEQ_RAW_RD, SEQ_POLL
  } cpm_seq_t;
  typedef enum logic [1:0] {SYM_IDLE, SYM_CONFIG, SYM_RANDOM} cpm_sym_t;
endpackage

// ### cpm_link_if.sv
`timescale 1ns/1ns
interface cpm_link_if;
  import cpm_pkg::*;
  logic           mgmt_req;
  logic           mgmt_we;
  logic [7:0]     mgmt_dev;
  logic [4:0]     mgmt_reg;
  logic [15:0]    mgmt_wdata;
  logic           mgmt_ack;
  logic [15:0]    mgmt_rdata;
  logic           tx_disable;
  logic           tx_fault;
  logic [15:0]    host_adv;
  logic           host_adv_vld;
  logic           an_ack;
  logic [15:0]    an_result;
  cpm_sym_t       rx_kind;
  logic [7:0]     rx_data;
  logic [7:0]     tx_data;
  modport dev  (input mgmt_req, mgmt_we, mgmt_dev, mgmt_reg, mgmt_wdata, tx_disable,
                host_adv, host_adv_vld, tx_data,
                output mgmt_ack, mgmt_rdata, tx_fault, an_ack, an_result, rx_kind, rx_data);
  modport host (output mgmt_req, mgmt_we, mgmt_dev, mgmt_reg, mgmt_wdata, tx_disable,
                host_adv, host_adv_vld, tx_data,
                input mgmt_ack, mgmt_rdata, tx_fault, an_ack, an_result, rx_kind, rx_data);
endinterface

// ### cpm_lfsr.sv
`timescale 1ns/1ns
module cpm_lfsr
(
  input  wire logic        clk,
  input  wire logic        rst_b,
  output logic [15:0]      state
);
  // Free running; seed only needs to be nonzero
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      state <= 16'hace1;
    else
      state <= {state[14:0], state[15] ^ state[13] ^ state[12] ^ state[10]};
  end
endmodule // cpm_lfsr

// ### cpm_dev.sv
// Implementation choice: strobed register access.
`timescale 1ns/1ns
// Operation
// RULE1: Hold host negotiation until cable side resolves
// RULE2: Merge host abilities, forward cable result
// RULE3: Idles when link good, else config/random
// RULE4: Link state readable at 0x11 bit 10
// RULE5: Preferred master; tie broken pseudo-randomly
// RULE6: Master local clock, slave recovered clock
// RULE7: Transmit fault output always low
// RULE8: Line loopback returns cable frames to cable
// RULE9: Line loopback only on established full-duplex link; controller gates SEQ_LLB_ON on last-read link-up only, duplex not checked
// RULE10: Register 0x14 bit 14 controls line loopback
// RULE11: Internal loopback echoes host, disables cable receive
// RULE12: Internal loopback needs host negotiation off first
// RULE13: Pulse-shape init writes then software reset
// RULE14: 0x1d selects internal register, 0x1e writes it
// RULE15: Serial-side negotiation off via bank sequence
// RULE16: 0x16 selects host or cable bank
// RULE17: Back-to-back: full duplex, no flow control
// RULE18: Back-to-back: controller polls link status
// RULE19: Transmit-disable holds reset, blocks register access
// RULE20: Device address 0xAC, sixteen-bit registers
// RULE21: Host negotiation off via bank sequence
// RULE22: Host negotiation on via bank sequence
// RULE23: Sequences issued strictly in order
module cpm_dev
(
  input  wire logic        clk,
  input  wire logic        rst_b,
  cpm_link_if.dev          link,
  input  wire logic        cable_link_up,
  input  wire logic        cable_an_done,
  input  wire logic [15:0] lp_abilities,
  input  wire logic        lp_pref_master,
  input  wire logic [7:0]  cable_rx_data,
  output logic [7:0]       cable_tx_data,
  output logic [15:0]      cable_adv,
  output logic             is_master,
  output logic             tx_clk_recovered,
  output logic             cable_rx_en
);
  import cpm_pkg::*;

  typedef enum logic [1:0] {HA_OFF, HA_LISTEN, HA_CABLE, HA_DONE} cpm_han_t;

  logic [15:0] ctrl_cu_r;
  logic [15:0] ctrl_host_r;
  logic [15:0] adv_r;
  logic [15:0] ext_r;
  logic [15:0] bank_r;
  logic [15:0] ptr_r;
  logic [15:0] ind_mem [16];
  logic [15:0] host_adv_r;
  logic [15:0] rdata_nxt;
  logic [15:0] rnd;
  logic [4:0]  rst_cnt_r;
  logic        ready;
  logic        wr;
  logic        hit;
  logic        host_bank;
  logic        han_restart;
  logic        int_lb;
  logic        line_lb;
  cpm_han_t    han_r;

  cpm_lfsr u_lfsr
  (
    .clk   (clk),
    .rst_b (rst_b),
    .state (rnd)
  );

  // Reset completion counter restarts on every transmit-disable
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      rst_cnt_r <= '0;
    else if (link.tx_disable)
      rst_cnt_r <= '0; // RULE19
    else if (rst_cnt_r != 5'(RST_DONE_CYC))
      rst_cnt_r <= rst_cnt_r + 5'd1;
  end

  assign ready     = !link.tx_disable && (rst_cnt_r == 5'(RST_DONE_CYC)); // RULE19
  assign hit       = link.mgmt_req && !link.mgmt_ack && ready &&
                     (link.mgmt_dev == MGMT_DEV_ADDR); // RULE20
  assign wr        = hit && link.mgmt_we;
  assign host_bank = (bank_r == BANK_HOST); // RULE16
  assign int_lb    = ctrl_cu_r[CTRL_LOOPBACK];
  assign line_lb   = ext_r[EXT_LINE_LB];
  assign han_restart = wr && host_bank && (link.mgmt_reg == REG_PHY_CTRL) &&
                       link.mgmt_wdata[CTRL_SOFT_RST];

  // Registers; soft reset bit self-clears by never being stored
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      ctrl_cu_r   <= CTRL_RST_VAL;
      ctrl_host_r <= CTRL_RST_VAL;
      adv_r       <= ADV_RST_VAL;
      ext_r       <= '0;
      bank_r      <= BANK_CABLE;
      ptr_r       <= '0;
    end
    else if (!ready)
    begin
      ctrl_cu_r   <= CTRL_RST_VAL; // RULE19
      ctrl_host_r <= CTRL_RST_VAL;
      adv_r       <= ADV_RST_VAL;
      ext_r       <= '0;
      bank_r      <= BANK_CABLE;
      ptr_r       <= '0;
    end
    else if (wr)
    begin
      unique case (link.mgmt_reg)
        REG_PHY_CTRL:
          if (host_bank) // RULE16
            ctrl_host_r <= link.mgmt_wdata & ~(16'h0001 << CTRL_SOFT_RST);
          else
            ctrl_cu_r <= link.mgmt_wdata & ~(16'h0001 << CTRL_SOFT_RST); // RULE11
        REG_ADV:      if (!host_bank) adv_r <= link.mgmt_wdata;
        REG_EXT_CTRL: if (!host_bank) ext_r <= link.mgmt_wdata; // RULE10
        REG_BANK_SEL: bank_r <= link.mgmt_wdata; // RULE16
        REG_IND_PTR:  ptr_r <= link.mgmt_wdata; // RULE14
        default:      ;
      endcase
    end
  end

  // Internal register file behind the pointer
  always_ff @(posedge clk)
  begin
    if (wr && link.mgmt_reg == REG_IND_DATA)
      ind_mem[ptr_r[3:0]] <= link.mgmt_wdata; // RULE14
  end

  always_comb
  begin
    rdata_nxt = '0;
    unique case (link.mgmt_reg)
      REG_PHY_CTRL:  rdata_nxt = host_bank ? ctrl_host_r : ctrl_cu_r;
      REG_ADV:       rdata_nxt = host_bank ? host_adv_r : adv_r;
      REG_LINK_STAT: rdata_nxt = 16'(cable_link_up) << STAT_LINK_UP; // RULE4
      REG_EXT_CTRL:  rdata_nxt = host_bank ? 16'h0000 : ext_r;
      REG_BANK_SEL:  rdata_nxt = bank_r;
      REG_IND_PTR:   rdata_nxt = ptr_r;
      REG_IND_DATA:  rdata_nxt = ind_mem[ptr_r[3:0]];
      default:       rdata_nxt = '0;
    endcase
  end

  // Unmapped offsets still answer, reading zero; no answer while in reset
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      link.mgmt_ack   <= 1'b0;
      link.mgmt_rdata <= '0;
    end
    else
    begin
      link.mgmt_ack   <= hit; // RULE19
      link.mgmt_rdata <= hit ? rdata_nxt : '0;
    end
  end

  // Host-side negotiation sequencing
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      han_r      <= HA_OFF;
      host_adv_r <= '0;
    end
    else if (!ready || !ctrl_host_r[CTRL_AN_EN] || int_lb)
      han_r <= HA_OFF; // RULE12
    else if (han_restart)
      han_r <= HA_LISTEN;
    else
    begin
      unique case (han_r)
        HA_OFF:    han_r <= HA_LISTEN;
        HA_LISTEN:
          if (link.host_adv_vld)
          begin
            host_adv_r <= link.host_adv; // RULE1
            han_r      <= HA_CABLE;
          end
        HA_CABLE:  if (cable_an_done && cable_link_up) han_r <= HA_DONE; // RULE1
        HA_DONE:   if (!cable_link_up) han_r <= HA_LISTEN;
      endcase
    end
  end

  // Cable advertisement carries the host's abilities once heard
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      cable_adv <= ADV_RST_VAL;
    else if (han_r == HA_CABLE || han_r == HA_DONE)
      cable_adv <= (adv_r & (host_adv_r | ~ADV_MERGE_MSK)) | (16'h0001 << ADV_PREF_MSTR); // RULE2
    else
      cable_adv <= adv_r | (16'h0001 << ADV_PREF_MSTR); // RULE5
  end

  // Nothing goes to the host until the cable side has resolved
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      link.an_ack    <= 1'b0;
      link.an_result <= '0;
    end
    else
    begin
      link.an_ack    <= (han_r == HA_DONE); // RULE1
      link.an_result <= (han_r == HA_DONE) ? (cable_adv & lp_abilities) : '0; // RULE2
    end
  end

  // Master/slave: tie resolved by the random generator, latched at resolution
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      is_master        <= 1'b1;
      tx_clk_recovered <= 1'b0;
    end
    else
    begin
      if (!cable_an_done)
        is_master <= lp_pref_master ? rnd[0] : 1'b1; // RULE5
      tx_clk_recovered <= !is_master; // RULE6
    end
  end

  // Host-facing stream
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      link.rx_kind <= SYM_RANDOM;
      link.rx_data <= '0;
      link.tx_fault <= 1'b0;
    end
    else
    begin
      link.tx_fault <= 1'b0; // RULE7
      if (int_lb)
      begin
        link.rx_kind <= SYM_IDLE;
        link.rx_data <= link.tx_data; // RULE11
      end
      else if (cable_link_up && (han_r == HA_DONE || han_r == HA_OFF))
      begin
        link.rx_kind <= SYM_IDLE; // RULE3
        link.rx_data <= line_lb ? 8'h00 : cable_rx_data; // RULE8
      end
      else if (han_r != HA_OFF)
      begin
        link.rx_kind <= SYM_CONFIG; // RULE3
        link.rx_data <= '0;
      end
      else
      begin
        link.rx_kind <= SYM_RANDOM; // RULE3
        link.rx_data <= rnd[7:0];
      end
    end
  end

  // Cable-facing side; receive shut off during internal loopback
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      cable_tx_data <= '0;
      cable_rx_en   <= 1'b0;
    end
    else
    begin
      cable_rx_en   <= ready && !int_lb; // RULE11
      cable_tx_data <= line_lb ? cable_rx_data : link.tx_data; // RULE8
    end
  end
endmodule // cpm_dev

// ### cpm_host.sv
`timescale 1ns/1ns
module cpm_host
(
  input  wire logic        clk,
  input  wire logic        rst_b,
  cpm_link_if.host         link,
  input  wire logic [3:0]  sw_addr,
  input  wire logic [15:0] sw_wdata,
  input  wire logic        sw_we,
  input  wire logic        sw_re,
  output logic [15:0]      sw_rdata,
  input  wire logic [15:0] mac_adv,
  input  wire logic        mac_adv_vld,
  input  wire logic [7:0]  mac_tx_data
);
  import cpm_pkg::*;

  typedef enum logic [1:0] {H_IDLE, H_REQ, H_NEXT} cpm_hst_t;

  cpm_hst_t    st_r;
  cpm_seq_t    seq_r;
  logic [2:0]  step_r;
  logic [1:0]  ctrl_r;
  logic [4:0]  raw_addr_r;
  logic [15:0] raw_data_r;
  logic [15:0] last_rd_r;
  logic        link_up_r;
  logic        refused_r;
  logic [4:0]  rst_cnt_r;
  logic [15:0] poll_cnt_r;
  logic [22:0] op;
  logic [22:0] op_nxt;
  logic        rst_ok;
  logic        start;
  logic        poll_due;

  // Entry: {valid, read, register, data}; steps run strictly in order
  function automatic logic [22:0] seq_op(cpm_seq_t s, logic [2:0] i,
                                         logic [4:0] ra, logic [15:0] rd);
    logic [22:0] e;
    e = '0;
    unique case (s)
      SEQ_PULSE: // RULE13
        unique case (i)
          3'd0: e = {2'b10, REG_IND_PTR, IND_PTR_A};
          3'd1: e = {2'b10, REG_IND_DATA, IND_DATA_A};
          3'd2: e = {2'b10, REG_IND_PTR, IND_PTR_B};
          3'd3: e = {2'b10, REG_IND_DATA, IND_DATA_B};
          3'd4: e = {2'b10, REG_PHY_CTRL, CTRL_AN_ON};
          default: e = '0;
        endcase
      SEQ_HAN_OFF, SEQ_HAN_ON, SEQ_ILB_ON: // RULE15 RULE21 RULE22 RULE12
        unique case (i)
          3'd0: e = {2'b10, REG_BANK_SEL, BANK_HOST};
          3'd1: e = {2'b10, REG_PHY_CTRL, (s == SEQ_HAN_ON) ? CTRL_AN_ON : CTRL_AN_OFF};
          3'd2: e = {2'b10, REG_BANK_SEL, BANK_CABLE};
          3'd3: e = (s == SEQ_ILB_ON) ? {2'b10, REG_PHY_CTRL, CTRL_ILB_ON} : '0;
          default: e = '0;
        endcase
      SEQ_ILB_OFF: // RULE12
        unique case (i)
          3'd0: e = {2'b10, REG_PHY_CTRL, CTRL_ILB_OFF};
          3'd1: e = {2'b10, REG_BANK_SEL, BANK_HOST};
          3'd2: e = {2'b10, REG_PHY_CTRL, CTRL_AN_ON};
          3'd3: e = {2'b10, REG_BANK_SEL, BANK_CABLE};
          default: e = '0;
        endcase
      SEQ_LLB_ON:  e = (i == 3'd0) ? {2'b10, REG_EXT_CTRL, EXT_LLB_ON} : '0; // RULE10
      SEQ_LLB_OFF: e = (i == 3'd0) ? {2'b10, REG_EXT_CTRL, EXT_LLB_OFF} : '0;
      SEQ_B2B: // RULE17
        unique case (i)
          3'd0: e = {2'b10, REG_ADV, ADV_B2B_FD};
          3'd1: e = {2'b10, REG_PHY_CTRL, CTRL_AN_ON};
          default: e = '0;
        endcase
      SEQ_RAW_WR: e = (i == 3'd0) ? {2'b10, ra, rd} : '0;
      SEQ_RAW_RD: e = (i == 3'd0) ? {2'b11, ra, 16'h0000} : '0;
      SEQ_POLL:   e = (i == 3'd0) ? {2'b11, REG_LINK_STAT, 16'h0000} : '0; // RULE18
      default:    e = '0;
    endcase
    return e;
  endfunction

  assign op       = seq_op(seq_r, step_r, raw_addr_r, raw_data_r);
  assign op_nxt   = seq_op(seq_r, step_r + 3'd1, raw_addr_r, raw_data_r);
  assign rst_ok   = !ctrl_r[0] && (rst_cnt_r == 5'(RST_DONE_CYC));
  assign start    = sw_we && sw_addr == HR_CMD && st_r == H_IDLE && rst_ok &&
                    sw_wdata[3:0] <= 4'(SEQ_RAW_RD);
  assign poll_due = ctrl_r[1] && poll_cnt_r == 16'(POLL_CYC);

  // No register access until transmit-disable is gone and reset has run
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      rst_cnt_r <= '0;
    else if (ctrl_r[0])
      rst_cnt_r <= '0; // RULE19
    else if (rst_cnt_r != 5'(RST_DONE_CYC))
      rst_cnt_r <= rst_cnt_r + 5'd1;
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      poll_cnt_r <= '0;
    else if (!ctrl_r[1] || (poll_due && st_r == H_IDLE && rst_ok && !start))
      poll_cnt_r <= '0;
    else if (!poll_due)
      poll_cnt_r <= poll_cnt_r + 16'd1;
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      ctrl_r     <= '0;
      raw_addr_r <= '0;
      raw_data_r <= '0;
    end
    else if (sw_we)
    begin
      if (sw_addr == HR_CTRL)     ctrl_r     <= sw_wdata[1:0];
      if (sw_addr == HR_RAW_ADDR) raw_addr_r <= sw_wdata[4:0];
      if (sw_addr == HR_RAW_DATA) raw_data_r <= sw_wdata;
    end
  end

  // Sequencer: one bus write completes before the next starts
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      st_r      <= H_IDLE;
      seq_r     <= SEQ_POLL;
      step_r    <= '0;
      refused_r <= 1'b0;
    end
    else
    begin
      unique case (st_r)
        H_IDLE:
          if (start && cpm_seq_t'(sw_wdata[3:0]) == SEQ_LLB_ON && !link_up_r)
            refused_r <= 1'b1; // RULE9
          else if (start)
          begin
            seq_r     <= cpm_seq_t'(sw_wdata[3:0]);
            step_r    <= '0;
            refused_r <= 1'b0;
            st_r      <= H_REQ;
          end
          else if (poll_due && rst_ok)
          begin
            seq_r  <= SEQ_POLL;
            step_r <= '0;
            st_r   <= H_REQ;
          end
        H_REQ:
          if (!rst_ok)
            st_r <= H_IDLE;
          else if (link.mgmt_ack)
            st_r <= H_NEXT; // RULE23
        H_NEXT:
        begin
          step_r <= step_r + 3'd1;
          st_r   <= op_nxt[22] ? H_REQ : H_IDLE;
        end
      endcase
    end
  end

  // Request held until answered
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      link.mgmt_req   <= 1'b0;
      link.mgmt_we    <= 1'b0;
      link.mgmt_dev   <= '0;
      link.mgmt_reg   <= '0;
      link.mgmt_wdata <= '0;
    end
    else
    begin
      link.mgmt_req   <= st_r == H_REQ && rst_ok && !link.mgmt_ack && !link.mgmt_req;
      if (st_r == H_REQ && link.mgmt_req && !link.mgmt_ack)
        link.mgmt_req <= 1'b1;
      link.mgmt_we    <= !op[21];
      link.mgmt_dev   <= MGMT_DEV_ADDR; // RULE20
      link.mgmt_reg   <= op[20:16];
      link.mgmt_wdata <= op[15:0];
    end
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      last_rd_r <= '0;
      link_up_r <= 1'b0;
    end
    else if (st_r == H_REQ && link.mgmt_ack && op[21])
    begin
      last_rd_r <= link.mgmt_rdata;
      if (seq_r == SEQ_POLL || op[20:16] == REG_LINK_STAT)
        link_up_r <= link.mgmt_rdata[STAT_LINK_UP]; // RULE18
    end
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      link.tx_disable   <= 1'b0;
      link.host_adv     <= '0;
      link.host_adv_vld <= 1'b0;
      link.tx_data      <= '0;
      sw_rdata          <= '0;
    end
    else
    begin
      link.tx_disable   <= ctrl_r[0]; // RULE19
      link.host_adv     <= mac_adv;
      link.host_adv_vld <= mac_adv_vld;
      link.tx_data      <= mac_tx_data;
      sw_rdata          <= '0;
      if (sw_re)
        unique case (sw_addr)
          HR_CTRL:     sw_rdata <= {14'h0000, ctrl_r};
          HR_RAW_ADDR: sw_rdata <= {11'h000, raw_addr_r};
          HR_RAW_DATA: sw_rdata <= raw_data_r;
          HR_STATUS:   sw_rdata <= {11'h000, link.an_ack, !rst_ok, refused_r, link_up_r,
                                    st_r != H_IDLE};
          HR_RDATA:    sw_rdata <= last_rd_r;
          default:     sw_rdata <= '0;
        endcase
    end
  end
endmodule // cpm_host

// ### cpm_asserts.sv
`timescale 1ns/1ns
module cpm_asserts
  import cpm_pkg::*;
(
  input wire logic        clk,
  input wire logic        rst_b,
  input wire logic        mgmt_req,
  input wire logic [7:0]  mgmt_dev,
  input wire logic        mgmt_ack,
  input wire logic [15:0] mgmt_rdata,
  input wire logic        tx_disable,
  input wire logic        tx_fault,
  input wire logic        host_adv_vld,
  input wire logic        an_ack,
  input wire logic [15:0] an_result
);
  // Two cycles of slack over the device's own wait count
  logic [6:0] rdy_r;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  always_ff @(posedge clk or negedge rst_b)
    if (!rst_b)
      rdy_r <= 7'h00;
    else if (tx_disable)
      rdy_r <= 7'h00;
    else if (rdy_r != 7'h7f)
      rdy_r <= rdy_r + 7'h01;
  AST_TXF_LOW: assert property (!tx_fault)
    else $error("fault output raised");
  AST_ACK_ONE: assert property (mgmt_ack |=> !mgmt_ack)
    else $error("ack longer than one cycle");
  AST_ACK_CAUSE: assert property (mgmt_ack |-> $past(mgmt_req) && !$past(tx_disable)
    && $past(mgmt_dev) == MGMT_DEV_ADDR)
    else $error("ack without valid request");
  AST_ACK_TIME: assert property ((mgmt_req && !mgmt_ack && mgmt_dev == MGMT_DEV_ADDR
    && !tx_disable && rdy_r >= RST_DONE_CYC + 2) |=> mgmt_ack)
    else $error("request not answered next cycle");
  AST_DIS_QUIET: assert property (tx_disable |=> !mgmt_ack [*8])
    else $error("access answered while disabled");
  AST_RDATA_IDLE: assert property (!mgmt_ack |-> mgmt_rdata == 16'h0000)
    else $error("read data outside ack");
  AST_AN_HOLD: assert property (!an_ack |-> an_result == 16'h0000)
    else $error("abilities passed before completion");
  AST_AN_CAUSE: assert property ($rose(an_ack) |-> $past(host_adv_vld, 2))
    else $error("completion without host abilities");
  AST_REQ_DROP: assert property (mgmt_ack |=> !mgmt_req)
    else $error("request held after ack");
  cover property (mgmt_ack && mgmt_req);
  cover property ($rose(an_ack));
  cover property ($fell(tx_disable));
endmodule // cpm_asserts

// ### copper_module_phy_config_test.sv
`timescale 1ns/1ns
module copper_module_phy_config_test;
  import cpm_pkg::*;
  logic        clk;
  logic        rst_b;
  logic [3:0]  sw_addr;
  logic [15:0] sw_wdata;
  logic        sw_we;
  logic        sw_re;
  logic [15:0] sw_rdata;
  logic [15:0] mac_adv;
  logic        mac_adv_vld;
  logic [7:0]  mac_tx_data;
  logic        cable_link_up;
  logic        cable_an_done;
  logic        lp_pref_master;
  logic [7:0]  cable_rx_data;
  logic [7:0]  cable_tx_data;
  logic [15:0] cable_adv;
  logic        is_master;
  logic        tx_clk_recovered;
  logic        cable_rx_en;
  logic [15:0] v;
  int          failures;
  int          n_checks;
  int          mdl[int];
  cpm_link_if cpm_link_if_i();
  cpm_dev cpm_dev_i (.clk(clk), .rst_b(rst_b), .link(cpm_link_if_i),
    .cable_link_up(cable_link_up), .cable_an_done(cable_an_done), .lp_abilities(mac_adv),
    .lp_pref_master(lp_pref_master), .cable_rx_data(cable_rx_data),
    .cable_tx_data(cable_tx_data), .cable_adv(cable_adv), .is_master(is_master),
    .tx_clk_recovered(tx_clk_recovered), .cable_rx_en(cable_rx_en));
  cpm_host cpm_host_i (.clk(clk), .rst_b(rst_b), .link(cpm_link_if_i), .sw_addr(sw_addr),
    .sw_wdata(sw_wdata), .sw_we(sw_we), .sw_re(sw_re), .sw_rdata(sw_rdata),
    .mac_adv(mac_adv), .mac_adv_vld(mac_adv_vld), .mac_tx_data(mac_tx_data));
  cpm_asserts cpm_asserts_i (.clk(clk), .rst_b(rst_b), .mgmt_req(cpm_link_if_i.mgmt_req),
    .mgmt_dev(cpm_link_if_i.mgmt_dev), .mgmt_ack(cpm_link_if_i.mgmt_ack),
    .mgmt_rdata(cpm_link_if_i.mgmt_rdata), .tx_disable(cpm_link_if_i.tx_disable),
    .tx_fault(cpm_link_if_i.tx_fault), .host_adv_vld(cpm_link_if_i.host_adv_vld),
    .an_ack(cpm_link_if_i.an_ack), .an_result(cpm_link_if_i.an_result));
  always #25 clk = ~clk;
  task automatic results();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      failures++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  // Extra idle edge so the strobe is never driven twice in one step
  task automatic wr(input logic [3:0] a, input logic [15:0] x);
    sw_addr <= a;
    sw_wdata <= x;
    sw_we <= 1'b1;
    @(posedge clk);
    sw_we <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [3:0] a, output logic [15:0] x);
    sw_addr <= a;
    sw_re <= 1'b1;
    @(posedge clk);
    sw_re <= 1'b0;
    #1 x = sw_rdata;
    @(posedge clk);
  endtask
  task automatic idle();
    logic [15:0] s;
    for (int i = 0; i < 100; i++)
    begin
      rd(HR_STATUS, s);
      if (s[0] === 1'b0)
        return;
    end
    chk(s, 16'h0000);
  endtask
  // Model ignores extended-control (0x14) writes while the host bank is mapped
  task automatic dwr(input logic [4:0] r, input logic [15:0] x);
    wr(HR_RAW_ADDR, {11'h000, r});
    wr(HR_RAW_DATA, x);
    wr(HR_CMD, 16'(SEQ_RAW_WR));
    idle();
    if (!(mdl[REG_BANK_SEL] == 1 && r == REG_EXT_CTRL))
      mdl[r] = x;
  endtask
  task automatic drd(input logic [4:0] r, output logic [15:0] x);
    wr(HR_RAW_ADDR, {11'h000, r});
    wr(HR_CMD, 16'(SEQ_RAW_RD));
    idle();
    rd(HR_RDATA, x);
  endtask
  task automatic dchk(input logic [4:0] r);
    drd(r, v);
    chk(v, 16'(mdl[r]));
  endtask
  initial
  begin
    repeat (30000) @(posedge clk);
    failures++;
    results();
  end
  initial
  begin
    clk = 1'b0;
    rst_b = 1'b0;
    {sw_addr, sw_wdata, sw_we, sw_re, mac_adv_vld, mac_tx_data, cable_rx_data} = '0;
    {cable_link_up, cable_an_done, lp_pref_master} = '0;
    void'($urandom(32'he009));
    mac_adv = 16'($urandom) | 16'h0400;
    mdl[REG_BANK_SEL] = 0;
    cyc(16);
    rst_b <= 1'b1;
    mac_adv_vld <= 1'b1;
    cyc(25);
    for (int i = 0; i < 4; i++)
    begin
      dwr(REG_IND_PTR, 16'($urandom));
      dchk(REG_IND_PTR);
    end
    wr(HR_CMD, 16'(SEQ_PULSE));
    idle();
    dwr(REG_IND_PTR, IND_PTR_A);
    drd(REG_IND_DATA, v);
    chk(v, IND_DATA_A);
    drd(5'h05, v);
    chk(v, 16'h0000);
    dwr(REG_EXT_CTRL, EXT_LLB_OFF);
    dwr(REG_BANK_SEL, BANK_HOST);
    dwr(REG_EXT_CTRL, EXT_LLB_ON);
    dchk(REG_BANK_SEL);
    dwr(REG_BANK_SEL, BANK_CABLE);
    dchk(REG_EXT_CTRL);
    cable_link_up <= 1'b1;
    drd(REG_LINK_STAT, v);
    chk(v[STAT_LINK_UP], 1'b1);
    rd(HR_STATUS, v);
    chk(v[4], 1'b0);
    dwr(REG_EXT_CTRL, EXT_LLB_ON);
    dchk(REG_EXT_CTRL);
    for (int i = 0; i < 3; i++)
    begin
      cable_rx_data <= 8'($urandom);
      cyc(4);
      chk(cable_tx_data, cable_rx_data);
      chk(cpm_link_if_i.rx_data, 16'h0000);
    end
    dwr(REG_EXT_CTRL, EXT_LLB_OFF);
    dchk(REG_EXT_CTRL);
    dwr(REG_PHY_CTRL, CTRL_ILB_ON);
    mac_tx_data <= 8'($urandom);
    cyc(4);
    chk(cpm_link_if_i.rx_data, mac_tx_data);
    chk(cable_rx_en, 1'b0);
    dwr(REG_PHY_CTRL, CTRL_ILB_OFF);
    cable_an_done <= 1'b1;
    cyc(8);
    rd(HR_STATUS, v);
    chk(v[4], 1'b1);
    chk(cable_adv & ADV_MERGE_MSK, mac_adv & ADV_MERGE_MSK);
    chk(is_master, 1'b1);
    chk(tx_clk_recovered, 1'b0);
    chk(cpm_link_if_i.rx_kind, SYM_IDLE);
    cable_link_up <= 1'b0;
    cyc(4);
    chk(cpm_link_if_i.rx_kind == SYM_IDLE, 1'b0);
    drd(REG_LINK_STAT, v);
    chk(v[STAT_LINK_UP], 1'b0);
    wr(HR_CMD, 16'(SEQ_LLB_ON));
    rd(HR_STATUS, v);
    chk(v[2], 1'b1);
    dchk(REG_EXT_CTRL);
    wr(HR_CMD, 16'(SEQ_B2B));
    idle();
    mdl[REG_ADV] = ADV_B2B_FD;
    dchk(REG_ADV);
    wr(HR_CMD, 16'(SEQ_HAN_OFF));
    idle();
    dwr(REG_BANK_SEL, BANK_HOST);
    drd(REG_PHY_CTRL, v);
    chk(v, CTRL_AN_OFF & ~(16'h0001 << CTRL_SOFT_RST));
    dwr(REG_BANK_SEL, BANK_CABLE);
    wr(HR_CTRL, 16'h0001);
    cyc(3);
    chk(cpm_link_if_i.tx_fault, 1'b0);
    rd(HR_STATUS, v);
    chk(v[3], 1'b1);
    wr(HR_CTRL, 16'h0000);
    cyc(25);
    drd(REG_IND_PTR, v);
    chk(v, 16'h0000);
    results();
  end
endmodule // copper_module_phy_config_test
